/* include/mmap_pkg.sv */
// Constants and types for the memory map and boot select block
// How it works
// - Core SRAM sits only at its own base until remap is commanded.
// - Backup SRAM always decodes at its own base.
// - After remap, core SRAM also appears at address zero.
// - Core SRAM mirrors every 4 KB and backup SRAM every 2 KB, each within its own area.
// - The 12 KB ROM always decodes at its own base.
// - Flash always decodes at its own base.
// - Boot bit set boots Flash; cleared, the default, boots ROM.
// - A valid clear-pin assertion clears the boot bit.
// - Clear pin is filtered on slow ticks; under 100 ms is ignored.
// - Selects for four 1 MB memory areas and one 256 MB peripheral area.
// - Every data access is alignment checked; misalignment aborts.
// - An abort records source, type and all access parameters.
// - Peripherals can be protected against writes, user access, or both.
// - Flash reads take zero to three programmable wait states.
// - A prefetch line buffer lets instruction fetches skip wait states.
// - A forbidden Flash operation raises the interrupt.
// - Flash pages are 256 bytes, 512 pages in one plane.
// - A 128-byte write buffer is filled through 32-bit writes.
// - Boot bit zero and no remap puts ROM at address zero.
package mmap_pkg;
  localparam int MCLK_HZ   = 25_000_000;
  localparam int SLOW_HZ   = 32_768;
  localparam int DEB_MS    = 100;
  localparam int REINIT_MS = 220;
  localparam int SLOW_DIV  = MCLK_HZ / SLOW_HZ;
  localparam int DEB_TICKS_DEF    = (DEB_MS * SLOW_HZ + 999) / 1000;
  localparam int REINIT_TICKS_DEF = (REINIT_MS * SLOW_HZ + 999) / 1000;
  localparam int WBUF_WORDS_DEF   = 32;
  localparam int DEB_W     = 16;
  localparam int DIV_W     = 10;
  // Areas of 1 MB, peripheral area is the top nibble
  localparam logic [11:0] AREA_ZERO  = 12'h000;
  localparam logic [11:0] AREA_FLASH = 12'h001;
  localparam logic [11:0] AREA_SRAM  = 12'h002;
  localparam logic [11:0] AREA_BKP   = 12'h003;
  localparam logic [11:0] AREA_ROM   = 12'h004;
  localparam logic [3:0]  PERIPH_NIB = 4'hF;
  localparam logic [19:0] ROM_LIMIT  = 20'h03000;
  localparam int SRAM_AW   = 12;
  localparam int BKP_AW    = 11;
  localparam int FLASH_AW  = 17;
  localparam int PAGE_LSB  = 8;
  localparam int PAGE_W    = 9;
  localparam int LINE_LSB  = 4;
  // Access sizes
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  // Register offsets
  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_FMODE = 8'h04;
  localparam logic [7:0] REG_PROT  = 8'h08;
  localparam logic [7:0] REG_ABST  = 8'h0C;
  localparam logic [7:0] REG_ABADR = 8'h10;
  localparam logic [7:0] REG_FCMD  = 8'h14;
  localparam logic [7:0] REG_FSTAT = 8'h18;
  // Field positions and reset values
  localparam int B_REMAP = 0;
  localparam int B_BSET  = 1;
  localparam int B_BCLR  = 2;
  localparam int B_PFEN  = 4;
  localparam int KEY_LSB = 24;
  localparam logic [1:0] RST_WAIT = 2'h3;
  localparam logic [7:0] FCMD_KEY = 8'h5A;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
  } acc_state_t;
endpackage

/* rtl/memory_map_boot_remap.sv */
// Memory map decoder, remap, boot select, abort and Flash front end
//
// The register offsets and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
module memory_map_boot_remap
  import mmap_pkg::*;
#(
  parameter int DEB_TICKS    = DEB_TICKS_DEF,
  parameter int REINIT_TICKS = REINIT_TICKS_DEF,
  parameter int WBUF_WORDS   = WBUF_WORDS_DEF
)(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Register bus
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // Master access port
  input  wire logic        acc_valid,
  input  wire logic        acc_src,
  input  wire logic [31:0] acc_addr,
  input  wire logic [1:0]  acc_size,
  input  wire logic        acc_write,
  input  wire logic        acc_fetch,
  input  wire logic        acc_user,
  input  wire logic [31:0] acc_wdata,
  output logic             acc_ready,
  output logic             acc_done,
  output logic             acc_abort,
  output logic             sel_flash,
  output logic             sel_sram,
  output logic             sel_bkp,
  output logic             sel_rom,
  output logic             sel_periph,
  output logic [19:0]      mem_offset,
  output logic [PAGE_W-1:0] flash_page,
  // Flash write buffer and commands
  input  wire logic [$clog2(WBUF_WORDS)-1:0] wbuf_idx,
  output logic [31:0]      wbuf_rdata,
  output logic             fcmd_valid,
  output logic [7:0]       fcmd_code,
  output logic [PAGE_W-1:0] fcmd_page,
  output logic             flash_irq,
  // Boot source and pins
  input  wire logic        boot_nv_in,
  input  wire logic        nv_clear_pin,
  input  wire logic        test_mode_pin,
  input  wire logic        clock_input_pin,
  input  wire logic        forced_wakeup_pin,
  output logic             boot_source_bit,
  output logic             nv_wr,
  output logic             nv_wdata,
  output logic             flash_reinit,
  output logic             fast_prog_mode
);
  localparam int WB_AW = $clog2(WBUF_WORDS);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [31:0]     wbuf [WBUF_WORDS];
  logic [2:0]      pin_s1_ff, pin_s2_ff;
  logic [DIV_W-1:0] div_ff;
  logic [DEB_W-1:0] deb_cnt_ff;
  logic            tick, pin_clr, init_ff;
  logic            remap_ff, boot_ff, fpm_ff;
  logic [1:0]      ws_ff, wcnt_ff;
  logic            pfen_ff, pwr_ff, pusr_ff;
  logic            wph_ff;
  logic [7:0]      wa_ff;
  logic            ahb_take, sw_set, sw_clr;
  logic [31:0]     rd_data;
  logic            take, zsel, rom_in, misal, prot_fail;
  logic            d_flash, d_sram, d_bkp, d_rom, d_per, d_abort;
  logic [11:0]     area;
  logic [19:0]     off, moff;
  logic            pf_hit, need_wait;
  logic [19-LINE_LSB:0] pf_tag_ff;
  logic            pf_val_ff;
  acc_state_t      st_ff;
  logic            ab_val_ff, ab_ovr_ff, ab_clr;
  logic [7:0]      ab_info_ff;
  logic [31:0]     ab_addr_ff;
  logic            fbad_ff, fcmd_wr, fbad_clr;

  // ----------------------------------------
  // Pin synchronisers and slow tick
  // ----------------------------------------
  always_ff @(posedge mclk)
  begin
    pin_s1_ff <= {nv_clear_pin, test_mode_pin, clock_input_pin};
    pin_s2_ff <= pin_s1_ff;
  end

  logic fw_s1_ff, fw_s2_ff;
  always_ff @(posedge mclk)
  begin
    fw_s1_ff <= forced_wakeup_pin;
    fw_s2_ff <= fw_s1_ff;
  end

  assign tick = (div_ff == DIV_W'(SLOW_DIV - 1));

  always_ff @(posedge mclk)
  begin
    if (rst || tick)
      div_ff <= '0;
    else
      div_ff <= div_ff + 1'b1;
  end

  // ----------------------------------------
  // Clear pin filter
  // ----------------------------------------
  // slow tick filter
  always_ff @(posedge mclk)
  begin
    if (rst || !pin_s2_ff[2])
      deb_cnt_ff <= '0;
    else if (tick && deb_cnt_ff != DEB_W'(REINIT_TICKS))
      deb_cnt_ff <= deb_cnt_ff + 1'b1;
  end

  assign pin_clr = tick && pin_s2_ff[2]
                   && deb_cnt_ff == DEB_W'(DEB_TICKS - 1);

  always_ff @(posedge mclk)
  begin
    if (rst)
      flash_reinit <= 1'b0;
    else
      flash_reinit <= tick && pin_s2_ff[2]
                      && deb_cnt_ff == DEB_W'(REINIT_TICKS - 1);
  end

  // ----------------------------------------
  // Boot source, straps and remap
  // ----------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst)
      init_ff <= 1'b0;
    else
      init_ff <= 1'b1;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      boot_ff <= 1'b0;
    else if (!init_ff)
      boot_ff <= boot_nv_in;
    else if (pin_clr || sw_clr)
      boot_ff <= 1'b0;
    else if (sw_set)
      boot_ff <= 1'b1;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      nv_wr    <= 1'b0;
      nv_wdata <= 1'b0;
    end
    else
    begin
      nv_wr    <= init_ff && (pin_clr || sw_clr || sw_set);
      nv_wdata <= !(pin_clr || sw_clr);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      fpm_ff <= 1'b0;
    else if (!init_ff)
      fpm_ff <= pin_s2_ff[1] && pin_s2_ff[0] && !fw_s2_ff;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      remap_ff <= 1'b0;
    else if (wph_ff && wa_ff == REG_CTRL && hwdata[B_REMAP])
      remap_ff <= 1'b1;
  end

  assign boot_source_bit = boot_ff;
  assign fast_prog_mode  = fpm_ff;

  // ----------------------------------------
  // Register bus slave
  // ----------------------------------------
  assign ahb_take  = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign sw_set = wph_ff && wa_ff == REG_CTRL && hwdata[B_BSET];
  assign sw_clr = wph_ff && wa_ff == REG_CTRL && hwdata[B_BCLR];
  assign ab_clr   = wph_ff && wa_ff == REG_ABST && hwdata[0];
  assign fbad_clr = wph_ff && wa_ff == REG_FSTAT && hwdata[0];
  assign fcmd_wr  = wph_ff && wa_ff == REG_FCMD;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      wph_ff <= 1'b0;
      wa_ff  <= '0;
      hrdata <= '0;
    end
    else
    begin
      wph_ff <= ahb_take && hwrite;
      wa_ff  <= haddr[7:0];
      if (ahb_take && !hwrite)
        hrdata <= rd_data;
    end
  end

  always_comb
  begin
    rd_data = 32'h00000000;
    unique case (haddr[7:0])
      REG_CTRL:  rd_data = {29'h0, fpm_ff, boot_ff, remap_ff};
      REG_FMODE: rd_data = {27'h0, pfen_ff, 2'h0, ws_ff};
      REG_PROT:  rd_data = {30'h0, pusr_ff, pwr_ff};
      REG_ABST:  rd_data = {16'h0, ab_info_ff, 6'h0, ab_ovr_ff,
                            ab_val_ff};
      REG_ABADR: rd_data = ab_addr_ff;
      REG_FSTAT: rd_data = {31'h0, fbad_ff};
      default:   rd_data = 32'h00000000;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ws_ff   <= RST_WAIT;
      pfen_ff <= 1'b0;
    end
    else if (wph_ff && wa_ff == REG_FMODE)
    begin
      ws_ff   <= hwdata[1:0];
      pfen_ff <= hwdata[B_PFEN];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      pwr_ff  <= 1'b0;
      pusr_ff <= 1'b0;
    end
    else if (wph_ff && wa_ff == REG_PROT)
    begin
      pwr_ff  <= hwdata[0];
      pusr_ff <= hwdata[1];
    end
  end

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  assign take = acc_valid && acc_ready;

  always_comb
  begin
    area   = acc_addr[31:20];
    off    = acc_addr[19:0];
    zsel   = (area == AREA_ZERO);
    rom_in = (off < ROM_LIMIT);
    d_sram  = (area == AREA_SRAM) || (zsel && remap_ff);
    d_flash = (area == AREA_FLASH) || (zsel && !remap_ff && boot_ff);
    d_rom   = ((area == AREA_ROM) || (zsel && !remap_ff && !boot_ff))
              && rom_in;
    d_bkp   = (area == AREA_BKP);
    d_per   = (acc_addr[31:28] == PERIPH_NIB);
    misal = !acc_fetch && ((acc_size == SZ_HALF && acc_addr[0])
            || (acc_size == SZ_WORD && acc_addr[1:0] != 2'h0));
    prot_fail = d_per && ((pwr_ff && acc_write) || (pusr_ff && acc_user));
    d_abort = misal || prot_fail
              || !(d_sram || d_flash || d_rom || d_bkp || d_per);
    moff = off;
    if (d_sram)
      moff = {{(20-SRAM_AW){1'b0}}, off[SRAM_AW-1:0]};
    else if (d_bkp)
      moff = {{(20-BKP_AW){1'b0}}, off[BKP_AW-1:0]};
    else if (d_flash)
      moff = {{(20-FLASH_AW){1'b0}}, off[FLASH_AW-1:0]};
  end

  assign pf_hit = pfen_ff && pf_val_ff && acc_fetch
                  && pf_tag_ff == off[19:LINE_LSB];
  assign need_wait = d_flash && !acc_write && !d_abort && !pf_hit
                     && ws_ff != 2'h0;

  // ----------------------------------------
  // Access sequencer
  // ----------------------------------------
  assign acc_ready = (st_ff == ST_IDLE);

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      sel_flash  <= 1'b0;
      sel_sram   <= 1'b0;
      sel_bkp    <= 1'b0;
      sel_rom    <= 1'b0;
      sel_periph <= 1'b0;
      acc_abort  <= 1'b0;
      mem_offset <= '0;
      flash_page <= '0;
    end
    else if (take)
    begin
      sel_flash  <= d_flash && !d_abort;
      sel_sram   <= d_sram && !d_abort;
      sel_bkp    <= d_bkp && !d_abort;
      sel_rom    <= d_rom && !d_abort;
      sel_periph <= d_per && !d_abort;
      acc_abort  <= d_abort;
      mem_offset <= moff;
      flash_page <= moff[PAGE_LSB +: PAGE_W];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      st_ff    <= ST_IDLE;
      wcnt_ff  <= '0;
      acc_done <= 1'b0;
    end
    else
    begin
      acc_done <= 1'b0;
      unique case (st_ff)
        ST_IDLE:
          if (take && need_wait)
          begin
            st_ff   <= ST_WAIT;
            wcnt_ff <= ws_ff - 2'h1;
          end
          else if (take)
            acc_done <= 1'b1;
        ST_WAIT:
          if (wcnt_ff == 2'h0)
          begin
            st_ff    <= ST_IDLE;
            acc_done <= 1'b1;
          end
          else
            wcnt_ff <= wcnt_ff - 2'h1;
        default:
          st_ff <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst || !pfen_ff)
    begin
      pf_val_ff <= 1'b0;
      pf_tag_ff <= '0;
    end
    else if (take && acc_fetch && d_flash && !d_abort)
    begin
      pf_val_ff <= 1'b1;
      pf_tag_ff <= off[19:LINE_LSB];
    end
  end

  // ----------------------------------------
  // Abort status
  // ----------------------------------------
  // abort record, set wins
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ab_val_ff  <= 1'b0;
      ab_ovr_ff  <= 1'b0;
      ab_info_ff <= '0;
      ab_addr_ff <= '0;
    end
    else
    begin
      ab_val_ff <= (take && d_abort) || (ab_val_ff && !ab_clr);
      ab_ovr_ff <= (take && d_abort && ab_val_ff && !ab_clr)
                   || (ab_ovr_ff && !ab_clr);
      if (take && d_abort && (!ab_val_ff || ab_clr))
      begin
        ab_info_ff <= {prot_fail, misal, acc_user, acc_src,
                       acc_fetch, acc_write, acc_size};
        ab_addr_ff <= acc_addr;
      end
    end
  end

  // ----------------------------------------
  // Flash write buffer and commands
  // ----------------------------------------
  // word writes fill buffer
  always_ff @(posedge mclk)
  begin
    if (take && !d_abort && d_flash && acc_write && acc_size == SZ_WORD)
      wbuf[off[WB_AW+1:2]] <= acc_wdata;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      wbuf_rdata <= '0;
    else
      wbuf_rdata <= wbuf[wbuf_idx];
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      fbad_ff    <= 1'b0;
      fcmd_valid <= 1'b0;
      fcmd_code  <= '0;
      fcmd_page  <= '0;
    end
    else
    begin
      fcmd_valid <= fcmd_wr && hwdata[KEY_LSB +: 8] == FCMD_KEY;
      if (fcmd_wr)
      begin
        fcmd_code <= hwdata[7:0];
        fcmd_page <= hwdata[PAGE_LSB +: PAGE_W];
      end
      fbad_ff <= (fcmd_wr && hwdata[KEY_LSB +: 8] != FCMD_KEY)
                 || (fbad_ff && !fbad_clr);
    end
  end

  assign flash_irq = fbad_ff;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  chk_sram_no_zero: assert property (
    take && zsel && !remap_ff |=> !sel_sram)
    else $error("core sram decoded at zero before remap");
  chk_bkp_base: assert property (
    take && area == AREA_BKP && !misal |=> sel_bkp && !acc_abort)
    else $error("backup sram not selected");
  chk_remap_alias: assert property (
    take && zsel && remap_ff && !misal |=> sel_sram)
    else $error("core sram missing at zero after remap");
  chk_rom_base: assert property (
    take && area == AREA_ROM && rom_in && !misal |=> sel_rom)
    else $error("rom not selected at base");
  chk_boot_alias: assert property (
    take && zsel && !remap_ff && rom_in && !misal
    |=> sel_flash == $past(boot_ff) && sel_rom == !$past(boot_ff))
    else $error("wrong boot alias at zero");
  chk_misalign_abort: assert property (
    take && !acc_fetch && acc_size == SZ_WORD
    && acc_addr[1:0] != 2'h0 |=> acc_abort)
    else $error("misaligned word not aborted");
  chk_abort_record: assert property (
    take && d_abort && !ab_val_ff
    |=> ab_val_ff && ab_addr_ff == $past(acc_addr))
    else $error("abort not recorded");
  chk_wait_two: assert property (
    take && need_wait && ws_ff == 2'h2
    |=> !acc_done ##1 !acc_done ##1 acc_done)
    else $error("two wait states not honoured");
  chk_clear_filter: assert property (
    $fell(boot_ff) && !$past(sw_clr) |-> deb_cnt_ff == DEB_W'(DEB_TICKS))
    else $error("boot bit cleared by short pulse");
  chk_bad_key_irq: assert property (
    fcmd_wr && hwdata[KEY_LSB +: 8] != FCMD_KEY |=> flash_irq && !fcmd_valid)
    else $error("forbidden command not flagged");

  cov_remap_zero: cover property (take && zsel && remap_ff);
  cov_abort: cover property (take && d_abort);
  cov_reinit: cover property (flash_reinit);
endmodule
`default_nettype wire

/* tb/access_master_model.sv */
// Bus master model driving the access port
`timescale 1ns/1ns
`default_nettype none
module access_master_model (
  // Clock
  input  wire logic        mclk,
  // Access port
  output logic             acc_valid,
  output logic             acc_src,
  output logic [31:0]      acc_addr,
  output logic [1:0]       acc_size,
  output logic             acc_write,
  output logic             acc_fetch,
  output logic             acc_user,
  output logic [31:0]      acc_wdata,
  input  wire logic        acc_ready,
  input  wire logic        acc_done
);
  initial
  begin
    acc_valid = 1'b0;
    {acc_src, acc_write, acc_fetch, acc_user} = 4'h0;
    acc_addr  = 32'h0000_0000;
    acc_size  = 2'h2;
    acc_wdata = 32'h0000_0000;
  end
  // Hold request until taken; n is wait cycles before done
  task automatic access(input logic [31:0] a, input logic [1:0] sz,
    input logic [3:0] at, input logic [31:0] wd, input int gap,
    output int n);
    n = 0;
    repeat (gap) @(posedge mclk);
    @(posedge mclk);
    acc_valid <= 1'b1;
    acc_addr  <= a;
    acc_size  <= sz;
    {acc_src, acc_write, acc_fetch, acc_user} <= at;
    acc_wdata <= wd;
    @(negedge mclk);
    while (acc_ready !== 1'b1) @(negedge mclk);
    @(posedge mclk);
    acc_valid <= 1'b0;
    acc_addr  <= ~a;
    acc_wdata <= ~wd;
    @(negedge mclk);
    while (acc_done !== 1'b1 && n < 64)
    begin
      @(negedge mclk);
      n++;
    end
  endtask
endmodule
`default_nettype wire

/* tb/memory_map_boot_remap_bench.sv */
// Self-checking bench for the memory map and boot select block
`timescale 1ns/1ns
`default_nettype none
module memory_map_boot_remap_bench;
  import mmap_pkg::*;
  logic mclk, rst, hsel, hwrite, boot_nv_in, nv_clear_pin;
  logic test_mode_pin, clock_input_pin, forced_wakeup_pin;
  logic [31:0] haddr, hwdata, hrdata, acc_addr, acc_wdata, wbuf_rdata;
  logic [1:0] htrans, acc_size;
  logic [2:0] hsize;
  logic [4:0] wbuf_idx, sels;
  logic hreadyout, hresp, acc_valid, acc_src, acc_write, acc_fetch;
  logic acc_user, acc_ready, acc_done, acc_abort, sel_flash, sel_sram;
  logic sel_bkp, sel_rom, sel_periph, fcmd_valid, flash_irq, nv_wr;
  logic boot_source_bit, nv_wdata, flash_reinit, fast_prog_mode;
  logic [19:0] mem_offset;
  logic [8:0] flash_page, fcmd_page;
  logic [7:0] fcmd_code;
  logic [31:0] rnd, rd, wd;
  int n, n_errors, samples_checked, clr_seen, reinit_seen, cmd_seen;
  logic [31:0] map_tab [0:8] = '{32'h0, 32'h0010_0000, 32'h0020_0000,
    32'h0030_0000, 32'h0040_0000, 32'h0040_2FFC, 32'hFFFF_F000,
    32'h002F_F000, 32'h002F_FFFC};
  assign sels = {sel_flash, sel_sram, sel_bkp, sel_rom, sel_periph};
  memory_map_boot_remap #(.DEB_TICKS(4), .REINIT_TICKS(8),
    .WBUF_WORDS(32)) memory_map_boot_remap_i (.hready(hreadyout), .*);
  access_master_model access_master_model_i (.*);
  // ------------------------------------------------------------
  // Clock, helpers and expectations
  // ------------------------------------------------------------
  always #20 mclk = ~mclk;
  always @(negedge mclk)
  begin
    if (nv_wr === 1'b1 && nv_wdata === 1'b0) clr_seen++;
    if (flash_reinit === 1'b1) reinit_seen++;
    if (fcmd_valid === 1'b1) cmd_seen++;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [4:0] exp_sel(input logic [31:0] a,
    input logic boot, input logic remap);
    if (a[31:28] == 4'hF) return 5'h01;
    case (a[31:20])
      12'h000: return remap ? 5'h08 : (boot ? 5'h10 : 5'h02);
      12'h001: return 5'h10;
      12'h002: return 5'h08;
      12'h003: return 5'h04;
      12'h004: return (a[19:0] < 20'h03000) ? 5'h02 : 5'h00;
      default: return 5'h00;
    endcase
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    if (n_errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic ahb(input logic w, input logic [7:0] off,
    input logic [31:0] d);
    @(posedge mclk);
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, 24'h0, off};
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    rd = hrdata;
  endtask
  task automatic acc(input logic [31:0] a, input logic [1:0] sz,
    input logic [3:0] at);
    rnd = lfsr(rnd);
    access_master_model_i.access(a, sz, at, wd, int'(rnd[0]), n);
  endtask
  task automatic do_reset(input logic boot, input logic strap);
    @(posedge mclk);
    rst <= 1'b1;
    boot_nv_in <= boot;
    {test_mode_pin, clock_input_pin, forced_wakeup_pin} <=
      {strap, strap, ~strap};
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
  endtask
  // ------------------------------------------------------------
  // Watchdog and main sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (60000) @(posedge mclk);
    n_errors++;
    report_and_stop;
  end
  initial
  begin
    {mclk, rst, hsel, hwrite, nv_clear_pin} = 5'h08;
    {haddr, hwdata, htrans, hsize, wbuf_idx, wd} = '0;
    hsize = 3'h2;
    rnd = 32'h0001_6590;
    n_errors = 0;
    samples_checked = 0;
    do_reset(1'b0, 1'b0);
    check(boot_source_bit, 0);
    for (int i = 0; i < 9; i++)
    begin
      acc(map_tab[i], 2'h2, 4'h0);
      check(sels, exp_sel(map_tab[i], 1'b0, 1'b0));
    end
    check(mem_offset, 20'h00FFC);
    acc(32'h0040_3000, 2'h2, 4'h0);
    check(acc_abort, 1);
    ahb(1'b1, REG_ABST, 1);
    acc(32'h0020_0002, 2'h2, 4'h8);
    check({acc_abort, sels}, 6'h20);
    ahb(1'b0, REG_ABST, 0);
    check(rd, 32'h0000_5201);
    check({hreadyout, hresp}, 2'h2);
    ahb(1'b0, REG_ABADR, 0);
    check(rd, 32'h0020_0002);
    ahb(1'b1, REG_ABST, 1);
    ahb(1'b0, REG_ABST, 0);
    check(rd[0], 0);
    acc(32'h0020_0002, 2'h1, 4'h0);
    check(acc_abort, 0);
    for (int p = 0; p < 4; p++)
    begin
      ahb(1'b1, REG_PROT, p);
      acc(32'hFFFA_0000, 2'h2, 4'h4);
      check(acc_abort, p[0]);
      acc(32'hFFFA_0000, 2'h2, 4'h1);
      check(acc_abort, p[1]);
    end
    for (int w = 0; w < 4; w++)
    begin
      ahb(1'b1, REG_FMODE, w);
      acc(32'h0010_0040 + w * 32, 2'h2, 4'h0);
      check(n, w);
    end
    ahb(1'b1, REG_FMODE, 32'h13);
    acc(32'h0010_0100, 2'h2, 4'h2);
    check(n, 3);
    acc(32'h0010_0104, 2'h2, 4'h2);
    check(n, 0);
    ahb(1'b1, REG_FCMD, 32'h1100_0001);
    repeat (3) @(negedge mclk);
    check(flash_irq, 1);
    ahb(1'b1, REG_FSTAT, 1);
    repeat (3) @(negedge mclk);
    check(flash_irq, 0);
    ahb(1'b1, REG_FCMD, {FCMD_KEY, 24'h00_1234});
    repeat (3) @(negedge mclk);
    check(cmd_seen, 1);
    check(flash_irq, 0);
    check({fcmd_page, fcmd_code}, {9'h012, 8'h34});
    for (int i = 0; i < 6; i++)
    begin
      rnd = lfsr(rnd);
      wd = rnd;
      acc({15'h0008, wd[16:2], 2'h0}, 2'h2, 4'h4);
      check(flash_page, wd[16:8]);
      @(posedge mclk);
      wbuf_idx <= wd[6:2];
      repeat (2) @(negedge mclk);
      check(wbuf_rdata, wd);
    end
    ahb(1'b0, 8'h1C, 0);
    check(rd, 0);
    ahb(1'b1, REG_CTRL, 1);
    acc(32'h0, 2'h2, 4'h0);
    check(sels, exp_sel(0, 1'b0, 1'b1));
    acc(32'h0020_0010, 2'h2, 4'h0);
    check(mem_offset, 20'h00010);
    do_reset(1'b1, 1'b1);
    check({boot_source_bit, fast_prog_mode}, 2'h3);
    acc(32'h0, 2'h2, 4'h0);
    check(sels, exp_sel(0, 1'b1, 1'b0));
    nv_clear_pin <= 1'b1;
    repeat (1524) @(posedge mclk);
    nv_clear_pin <= 1'b0;
    repeat (10) @(negedge mclk);
    check({boot_source_bit, clr_seen[0]}, 2'h2);
    // pin held well past the reinit time
    nv_clear_pin <= 1'b1;
    repeat (8500) @(posedge mclk);
    nv_clear_pin <= 1'b0;
    repeat (10) @(negedge mclk);
    check(boot_source_bit, 0);
    check(clr_seen, 1);
    check(reinit_seen, 1);
    report_and_stop;
  end
endmodule
`default_nettype wire
